// ===== shared/smb_pkg.sv
// constants and types shared by the serial media bridge latency datapath
package smb_pkg;
    localparam int CLK_NS   = 4;           // core clock period in ns
    localparam int STAMP_W  = 16;          // width of the arrival stamp
    localparam int DATA_W   = 8;           // payload byte width
    // ring entry field positions
    localparam int ENT_DATA = 0;           // payload byte lsb
    localparam int ENT_SOP  = 8;           // start-of-packet flag
    localparam int ENT_EOP  = 9;           // terminate flag
    localparam int ENT_STMP = 10;          // stamp lsb
    localparam int ENT_W    = 26;          // whole entry width
    // link speed encodings
    localparam logic [1:0] SPD_1000 = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_10   = 2'h2;
    localparam logic [3:0] SFD_NIBBLE = 4'hd; // frame delimiter nibble
    // forwarding paths
    typedef enum logic [1:0] {
        PATH_Q2S  = 2'b00,                 // quad in to single out
        PATH_S2Q  = 2'b01,                 // single in to quad out
        PATH_S2S  = 2'b10,                 // single in looped to single out
        PATH_CU2S = 2'b11                  // copper in to single out
    } smb_path_e;
    // copper receive framing states
    typedef enum logic [1:0] {
        CU_IDLE = 2'b00,                   // waiting for a start
        CU_PRE  = 2'b01,                   // 10 Mbps preamble, hunting delimiter
        CU_DATA = 2'b10                    // inside the frame
    } smb_cu_e;
    // least and longest latency in ns, [path][speed 1000/100/10]
    localparam int LAT_MIN_NS [4][3] = '{'{156, 520, 4212}, '{164, 472, 3804},
                                         '{252, 876, 7548}, '{404, 1048, 8577}};
    localparam int LAT_MAX_NS [4][3] = '{'{232, 700, 5472}, '{224, 636, 5048},
                                         '{336, 1172, 10008}, '{484, 1300, 10583}};
    localparam int STEP_NS [3] = '{8, 40, 400};  // added per depth step
    localparam int BYTE_NS [3] = '{8, 80, 800};  // egress byte slot
endpackage : smb_pkg

// ===== shared/smb_fifo_if.sv
// carrier between the bridge core and its elastic fifo
`timescale 1ns/1ps
`default_nettype none
interface smb_fifo_if #(parameter int W = 26);
    logic [W-1:0] wdata;   // word offered for writing
    logic         wvalid;  // write offer
    logic         wready;  // fifo has room
    logic [W-1:0] rdata;   // head word
    logic         rvalid;  // fifo holds a word
    logic         rready;  // reader takes the head
    modport fifo (input wdata, wvalid, rready, output wready, rdata, rvalid);
    modport user (output wdata, wvalid, rready, input wready, rdata, rvalid);
endinterface : smb_fifo_if
`default_nettype wire

// ===== rtl/smb_fifo.sv
// elastic fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module smb_fifo #(
    parameter int W     = 26,
    parameter int DEPTH = 8
) (
    input  wire logic clk,
    input  wire logic rst_n,
    smb_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);

    // refuse depths the pointer wrap cannot serve, at elaboration
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad_depth
        $error("smb_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;  // storage words
        logic [AW-1:0]           wp;   // write pointer
        logic [AW-1:0]           rp;   // read pointer
        logic [AW:0]             cnt;  // words held
    } smb_fifo_s;

    smb_fifo_s st;
    smb_fifo_s nx;
    logic      wr;
    logic      rd;

    // honest flags from the count
    assign f.wready = (st.cnt != (AW+1)'(DEPTH));
    assign f.rvalid = (st.cnt != '0);
    assign f.rdata  = st.mem[st.rp];

    // next state: write, read, count
    always_comb begin
        nx = st;
        wr = f.wvalid && f.wready;
        rd = f.rready && f.rvalid;
        if (wr) begin
            nx.mem[st.wp] = f.wdata;
            nx.wp         = st.wp + 1'b1;
        end
        if (rd) begin
            nx.rp = st.rp + 1'b1;
        end
        nx.cnt = st.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end
endmodule : smb_fifo
`default_nettype wire

// ===== rtl/smb_latency_top.sv
// serial media bridge forwarding datapath with latency shaping
// Notes on behaviour
// - quad to single gig latency 156..232 ns
// - quad to single 100M latency 520..700 ns
// - quad to single 10M latency 4212..5472 ns
// - single to quad gig latency 164..224 ns
// - single to quad 100M latency 472..636 ns
// - single to quad 10M latency 3804..5048 ns
// - single loop gig latency 252..336 ns
// - single loop 100M latency 876..1172 ns
// - single loop 10M latency 7548..10008 ns
// - copper gig start to single 404..484 ns
// - copper gig end codes to terminate likewise
// - copper 100M start, end within 1048..1300 ns
// - copper 10M preamble, delimiter within 8577..10583 ns
// - serial depth steps add 8/40/400 ns
// - copper depth field adds same steps
// - loop figures only with loop mode on
// - gig copper timed from latest of four pairs
// - 10M aligns nibbles to delimiter, drops dribble
// - end bounds assume zero clock drift
`timescale 1ns/1ps
`default_nettype none
module smb_latency_top #(
    parameter int RING  = 32,  // in-flight words per path
    parameter int FIFOD = 8    // elastic fifo depth
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    input  wire logic [1:0] LINK_SPEED,
    input  wire logic       AUTO_MEDIA_LAT,
    input  wire logic       COPPER_SEL,
    input  wire logic [1:0] SER_BUF_DEPTH,
    input  wire logic [1:0] CU_BUF_DEPTH,
    input  wire logic [7:0] QUAD_SERIAL_RX_DATA,
    input  wire logic       QUAD_SERIAL_RX_VALID,
    input  wire logic       QUAD_SERIAL_RX_SOP,
    input  wire logic       QUAD_SERIAL_RX_EOP,
    output logic            QUAD_SERIAL_RX_READY,
    input  wire logic [7:0] SINGLE_SERIAL_RX_DATA,
    input  wire logic       SINGLE_SERIAL_RX_VALID,
    input  wire logic       SINGLE_SERIAL_RX_SOP,
    input  wire logic       SINGLE_SERIAL_RX_EOP,
    output logic            SINGLE_SERIAL_RX_READY,
    input  wire logic [7:0] COPPER_MEDIA_RX_DATA,
    input  wire logic       COPPER_MEDIA_RX_VALID,
    input  wire logic       COPPER_MEDIA_RX_SOP,
    input  wire logic       COPPER_MEDIA_RX_EOP,
    input  wire logic [3:0] COPPER_MEDIA_PAIRS_LOCK,
    output logic [7:0]      SINGLE_SERIAL_TX_DATA,
    output logic            SINGLE_SERIAL_TX_VALID,
    output logic            SINGLE_SERIAL_TX_SOP,
    output logic            SINGLE_SERIAL_TX_EOP,
    output logic [7:0]      QUAD_SERIAL_TX_DATA,
    output logic            QUAD_SERIAL_TX_VALID,
    output logic            QUAD_SERIAL_TX_SOP,
    output logic            QUAD_SERIAL_TX_EOP
);
    localparam int PW = $clog2(RING);
    localparam int SW = smb_pkg::STAMP_W;
    localparam int EW = smb_pkg::ENT_W;

    // refuse ring sizes the pointer wrap cannot serve, at elaboration
    if (RING < 8 || (RING & (RING - 1)) != 0) begin : g_bad_ring
        $error("smb_latency_top: RING must be a power of two of at least 8");
    end

    typedef struct packed {
        logic [SW-1:0]                now;      // free-running stamp clock
        logic [7:0]                   pace;     // egress slot divider
        logic                         pace_en;  // one-cycle egress slot
        smb_pkg::smb_cu_e             cu;       // copper framing state
        logic                         cu_half;  // low nibble held
        logic                         cu_first; // next byte opens frame
        logic [3:0]                   cu_lo;    // held low nibble
        logic [1:0][RING-1:0][EW-1:0] ring;     // in-flight words per path
        logic [1:0][PW-1:0]           wp;       // ring write pointers
        logic [1:0][PW-1:0]           rp;       // ring read pointers
        logic [1:0][PW:0]             cnt;      // ring fill
        logic                         q_rdy;    // quad ingress ready
        logic                         s_rdy;    // single ingress ready
        logic [1:0][7:0]              o_data;   // egress byte
        logic [1:0]                   o_sop;    // egress start
        logic [1:0]                   o_eop;    // egress terminate
        logic [1:0]                   o_val;    // egress strobe
        logic [1:0][SW-1:0]           o_age;    // latency of egress word
    } smb_state_s;

    smb_state_s          st;
    smb_state_s          nx;
    logic [1:0]          rsync;   // reset release stages
    logic                rst_n;   // released reset copy
    logic                loop;    // loop latency mode
    logic [1:0]          spd;     // clamped speed
    smb_pkg::smb_path_e  src0;    // source feeding single out
    logic [1:0]          dep0;    // depth setting of single-out path
    logic [1:0][SW-1:0]  tgt;     // least latency per path in cycles
    logic [1:0]          w_en;    // ring write per path
    logic [1:0][EW-1:0]  w_ent;   // ring write entry
    logic [1:0]          rel;     // ring release per path
    logic [1:0][SW-1:0]  age;     // age of ring head
    logic                cu_v;    // copper word ready for ring
    logic                cu_s;    // copper start flag
    logic                cu_e;    // copper terminate flag
    logic [7:0]          cu_d;    // copper byte
    logic [1:0]          f_wready;
    logic [1:0]          f_rvalid;
    logic [1:0][EW-1:0]  f_rdata;

    // least latency in cycles, rounded up, plus depth steps
    function automatic logic [SW-1:0] lat_min(input smb_pkg::smb_path_e p,
                                              input logic [1:0] sp,
                                              input logic [1:0] dep);
        int ns;
        ns = smb_pkg::LAT_MIN_NS[int'(p)][int'(sp)] + int'(dep) * smb_pkg::STEP_NS[int'(sp)];
        return SW'((ns + smb_pkg::CLK_NS - 1) / smb_pkg::CLK_NS);
    endfunction : lat_min

    // longest latency in cycles, rounded down
    function automatic logic [SW-1:0] lat_max(input smb_pkg::smb_path_e p,
                                              input logic [1:0] sp);
        return SW'(smb_pkg::LAT_MAX_NS[int'(p)][int'(sp)] / smb_pkg::CLK_NS);
    endfunction : lat_max

    // two-stage reset release
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rsync <= 2'h0;
        end else begin
            rsync <= {rsync[0], 1'b1};
        end
    end
    assign rst_n = rsync[1];

    // one elastic fifo per egress path
    generate
        for (genvar g = 0; g < 2; g++) begin : g_path
            smb_fifo_if #(.W(EW)) fi ();
            assign fi.wdata    = st.ring[g][st.rp[g]];
            assign fi.wvalid   = rel[g];
            assign fi.rready   = st.pace_en;
            assign f_wready[g] = fi.wready;
            assign f_rvalid[g] = fi.rvalid;
            assign f_rdata[g]  = fi.rdata;
            smb_fifo #(.W(EW), .DEPTH(FIFOD)) u_fifo (
                .clk   (CORE_CLK),
                .rst_n (rst_n),
                .f     (fi.fifo)
            );
        end
    endgenerate

    // next state of the whole datapath
    always_comb begin
        nx     = st;
        cu_v   = 1'b0;
        cu_s   = 1'b0;
        cu_e   = 1'b0;
        cu_d   = COPPER_MEDIA_RX_DATA;
        w_en   = '0;
        w_ent  = '0;
        rel    = '0;
        age    = '0;
        spd    = (LINK_SPEED == 2'h3) ? smb_pkg::SPD_10 : LINK_SPEED;
        loop   = AUTO_MEDIA_LAT;
        // loop mode steers single out from the looped single or copper input
        if (!loop) begin
            src0 = smb_pkg::PATH_Q2S;
        end else if (COPPER_SEL) begin
            src0 = smb_pkg::PATH_CU2S;
        end else begin
            src0 = smb_pkg::PATH_S2S;
        end
        // copper path uses its own depth field
        dep0   = (src0 == smb_pkg::PATH_CU2S) ? CU_BUF_DEPTH : SER_BUF_DEPTH;
        tgt[0] = lat_min(src0, spd, dep0);
        tgt[1] = lat_min(smb_pkg::PATH_S2Q, spd, SER_BUF_DEPTH);
        nx.now = st.now + 1'b1;

        // egress slot divider, one byte time per slot
        if (st.pace == 8'h00) begin
            nx.pace    = 8'((smb_pkg::BYTE_NS[int'(spd)] / smb_pkg::CLK_NS) - 1);
            nx.pace_en = 1'b1;
        end else begin
            nx.pace    = st.pace - 1'b1;
            nx.pace_en = 1'b0;
        end

        // copper receive framing
        if (COPPER_MEDIA_RX_VALID) begin
            case (st.cu)
                smb_pkg::CU_IDLE: begin
                    // gig start counts only once all pairs have arrived
                    if (COPPER_MEDIA_RX_SOP && (spd != smb_pkg::SPD_1000 ||
                                                &COPPER_MEDIA_PAIRS_LOCK)) begin
                        if (spd == smb_pkg::SPD_10) begin
                            nx.cu      = smb_pkg::CU_PRE;
                            nx.cu_half = 1'b0;
                        end else begin
                            nx.cu = smb_pkg::CU_DATA;
                            cu_v  = 1'b1;
                            cu_s  = 1'b1;
                        end
                    end
                end
                smb_pkg::CU_PRE: begin
                    // nibbles align to the delimiter
                    if (COPPER_MEDIA_RX_EOP) begin
                        nx.cu = smb_pkg::CU_IDLE;
                    end else if (COPPER_MEDIA_RX_DATA[3:0] == smb_pkg::SFD_NIBBLE) begin
                        nx.cu       = smb_pkg::CU_DATA;
                        nx.cu_first = 1'b1;
                        nx.cu_half  = 1'b0;
                    end
                end
                smb_pkg::CU_DATA: begin
                    if (COPPER_MEDIA_RX_EOP) begin
                        // end code becomes terminate, a held nibble is dribble
                        cu_v       = 1'b1;
                        cu_e       = 1'b1;
                        nx.cu      = smb_pkg::CU_IDLE;
                        nx.cu_half = 1'b0;
                    end else if (spd != smb_pkg::SPD_10) begin
                        cu_v = 1'b1;
                    end else if (!st.cu_half) begin
                        nx.cu_lo   = COPPER_MEDIA_RX_DATA[3:0];
                        nx.cu_half = 1'b1;
                    end else begin
                        // low nibble first, then high
                        cu_v        = 1'b1;
                        cu_d        = {COPPER_MEDIA_RX_DATA[3:0], st.cu_lo};
                        cu_s        = st.cu_first;
                        nx.cu_first = 1'b0;
                        nx.cu_half  = 1'b0;
                    end
                end
                default: begin
                    nx.cu = smb_pkg::CU_IDLE;
                end
            endcase
        end

        // ingress selection for single-out path
        case (src0)
            smb_pkg::PATH_Q2S: begin
                w_en[0]  = QUAD_SERIAL_RX_VALID && st.q_rdy;
                w_ent[0] = {st.now, QUAD_SERIAL_RX_EOP, QUAD_SERIAL_RX_SOP, QUAD_SERIAL_RX_DATA};
            end
            smb_pkg::PATH_S2S: begin
                w_en[0]  = SINGLE_SERIAL_RX_VALID && st.s_rdy;
                w_ent[0] = {st.now, SINGLE_SERIAL_RX_EOP, SINGLE_SERIAL_RX_SOP, SINGLE_SERIAL_RX_DATA};
            end
            default: begin
                w_en[0]  = cu_v && (st.cnt[0] != (PW+1)'(RING));
                w_ent[0] = {st.now, cu_e, cu_s, cu_d};
            end
        endcase
        // single in reaches quad out only outside loop mode
        w_en[1]  = !loop && SINGLE_SERIAL_RX_VALID && st.s_rdy;
        w_ent[1] = {st.now, SINGLE_SERIAL_RX_EOP, SINGLE_SERIAL_RX_SOP, SINGLE_SERIAL_RX_DATA};

        // per path: hold each word until due, then pass to the elastic fifo
        for (int g = 0; g < 2; g++) begin
            age[g] = st.now - st.ring[g][st.rp[g]][smb_pkg::ENT_STMP +: SW];
            // two cycles of fifo and egress register follow the release
            rel[g] = (st.cnt[g] != '0) && (age[g] >= tgt[g] - SW'(2)) && f_wready[g];
            if (rel[g]) begin
                nx.rp[g] = st.rp[g] + 1'b1;
            end
            if (w_en[g]) begin
                nx.ring[g][st.wp[g]] = w_ent[g];
                nx.wp[g]             = st.wp[g] + 1'b1;
            end
            nx.cnt[g] = st.cnt[g] + (PW+1)'(w_en[g]) - (PW+1)'(rel[g]);
            // fifo drains at the egress byte rate; equal rates assumed
            nx.o_val[g] = 1'b0;
            if (st.pace_en && f_rvalid[g]) begin
                nx.o_val[g]  = 1'b1;
                nx.o_data[g] = f_rdata[g][smb_pkg::ENT_DATA +: 8];
                nx.o_sop[g]  = f_rdata[g][smb_pkg::ENT_SOP];
                nx.o_eop[g]  = f_rdata[g][smb_pkg::ENT_EOP];
                nx.o_age[g]  = st.now - f_rdata[g][smb_pkg::ENT_STMP +: SW] + 1'b1;
            end
        end

        // back-pressure to the serial sources
        nx.q_rdy = !loop && (nx.cnt[0] != (PW+1)'(RING));
        nx.s_rdy = loop ? (!COPPER_SEL && (nx.cnt[0] != (PW+1)'(RING)))
                        : (nx.cnt[1] != (PW+1)'(RING));
    end

    // state register
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    // ports straight from state
    assign QUAD_SERIAL_RX_READY   = st.q_rdy;
    assign SINGLE_SERIAL_RX_READY = st.s_rdy;
    assign SINGLE_SERIAL_TX_DATA  = st.o_data[0];
    assign SINGLE_SERIAL_TX_VALID = st.o_val[0];
    assign SINGLE_SERIAL_TX_SOP   = st.o_sop[0];
    assign SINGLE_SERIAL_TX_EOP   = st.o_eop[0];
    assign QUAD_SERIAL_TX_DATA    = st.o_data[1];
    assign QUAD_SERIAL_TX_VALID   = st.o_val[1];
    assign QUAD_SERIAL_TX_SOP     = st.o_sop[1];
    assign QUAD_SERIAL_TX_EOP     = st.o_eop[1];

    // single out never leaves earlier than the least latency
    a_sout_min_lat: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st.o_val[0] |-> st.o_age[0] >= tgt[0])
        else $error("single out word left before its least latency");

    // single out within the longest latency at minimum depth
    a_sout_max_lat: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st.o_val[0] && dep0 == 2'h0 |-> st.o_age[0] <= lat_max(src0, spd))
        else $error("single out word exceeded its longest latency");

    // quad out word that opens a valid run never leaves earlier than the least latency
    a_qout_min_lat: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        $rose(st.o_val[1]) |-> st.o_age[1] >= tgt[1])
        else $error("quad out word left before its least latency");

    // quad out within the longest latency at minimum depth
    a_qout_max_lat: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st.o_val[1] && SER_BUF_DEPTH == 2'h0 |->
        st.o_age[1] <= lat_max(smb_pkg::PATH_S2Q, spd))
        else $error("quad out word exceeded its longest latency");

    // deepest setting adds three steps over the base
    a_depth_grows: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st.o_val[0] && !loop && SER_BUF_DEPTH == 2'h3 |->
        st.o_age[0] >= lat_min(smb_pkg::PATH_Q2S, spd, 2'h0) + SW'(3 * smb_pkg::STEP_NS[int'(spd)] / 4))
        else $error("depth setting did not add its latency");

    // in loop mode the quad ingress is refused
    a_loop_gate: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        loop |=> !st.q_rdy)
        else $error("quad ingress ready while in loop mode");

    // gig copper start only with all pairs arrived
    a_pairs_latest: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        cu_s && spd == smb_pkg::SPD_1000 |-> &COPPER_MEDIA_PAIRS_LOCK)
        else $error("copper start taken before the latest pair");

    // a held nibble at frame end is dropped
    a_dribble_drop: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        cu_e && spd == smb_pkg::SPD_10 |=> !st.cu_half && st.cu == smb_pkg::CU_IDLE)
        else $error("dribble nibble survived frame end");

    // rings never overrun
    a_no_overrun: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st.cnt[0] <= (PW+1)'(RING) && st.cnt[1] <= (PW+1)'(RING))
        else $error("ring fill exceeded its depth");
endmodule : smb_latency_top
`default_nettype wire

// ===== bench/smb_mac_model.sv
// host mac model that feeds one serial ingress lane
`timescale 1ns/1ps
`default_nettype none
module smb_mac_model (
    input  wire logic       clk,
    input  wire logic       ready,
    output logic [7:0]      data,
    output logic            valid,
    output logic            sop,
    output logic            eop
);
    // lane starts idle
    initial begin
        data  = 8'h00;
        valid = 1'b0;
        sop   = 1'b0;
        eop   = 1'b0;
    end
    // offer one word, hold it until taken; same clock both ends, no drift
    task automatic send(input logic [7:0] d, input logic s, input logic e, output time at);
        @(negedge clk);
        data  = d;
        valid = 1'b1;
        sop   = s;
        eop   = e;
        while (ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        at = $time;
    endtask : send
    // release the lane; data flips so a stale byte never looks valid
    task automatic idle();
        @(negedge clk);
        valid = 1'b0;
        sop   = 1'b0;
        eop   = 1'b0;
        data  = ~data;
    endtask : idle
endmodule : smb_mac_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the latency datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic       clk = 0, rst_n = 0, ams = 0, csel = 0, cv = 0, cs = 0, ce = 0;
    logic [1:0] spd = 0, sdep = 0, cdep = 0;
    logic [7:0] cd = 0;
    logic [3:0] lck = 0;
    logic [7:0] qd, sd, so_d, qo_d, d_ss, d_qs;
    logic       qv, qs, qe, qr, sv, ss, se, sr, so_v, so_s, so_e, qo_v, qo_s, qo_e;
    time        t0, t1, t_ss, t_se, t_qs, t_qe;
    int         cyc = 0, n_mismatch = 0, total_checks = 0;
    smb_mac_model mac_q (.clk(clk), .ready(qr), .data(qd), .valid(qv), .sop(qs), .eop(qe));
    smb_mac_model mac_s (.clk(clk), .ready(sr), .data(sd), .valid(sv), .sop(ss), .eop(se));
    smb_latency_top DUT (.CORE_CLK(clk), .RST_N(rst_n), .LINK_SPEED(spd), .AUTO_MEDIA_LAT(ams),
        .COPPER_SEL(csel), .SER_BUF_DEPTH(sdep), .CU_BUF_DEPTH(cdep), .QUAD_SERIAL_RX_DATA(qd),
        .QUAD_SERIAL_RX_VALID(qv), .QUAD_SERIAL_RX_SOP(qs), .QUAD_SERIAL_RX_EOP(qe),
        .QUAD_SERIAL_RX_READY(qr), .SINGLE_SERIAL_RX_DATA(sd), .SINGLE_SERIAL_RX_VALID(sv),
        .SINGLE_SERIAL_RX_SOP(ss), .SINGLE_SERIAL_RX_EOP(se), .SINGLE_SERIAL_RX_READY(sr),
        .COPPER_MEDIA_RX_DATA(cd), .COPPER_MEDIA_RX_VALID(cv), .COPPER_MEDIA_RX_SOP(cs),
        .COPPER_MEDIA_RX_EOP(ce), .COPPER_MEDIA_PAIRS_LOCK(lck), .SINGLE_SERIAL_TX_DATA(so_d),
        .SINGLE_SERIAL_TX_VALID(so_v), .SINGLE_SERIAL_TX_SOP(so_s), .SINGLE_SERIAL_TX_EOP(so_e),
        .QUAD_SERIAL_TX_DATA(qo_d), .QUAD_SERIAL_TX_VALID(qo_v), .QUAD_SERIAL_TX_SOP(qo_s),
        .QUAD_SERIAL_TX_EOP(qo_e));
    // clock of 4 ns period
    initial forever #2 clk = ~clk;
    // stamp egress start and terminate words; cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (so_v && so_s) t_ss = $time;
        if (so_v && so_s) d_ss = so_d;
        if (so_v && so_e) t_se = $time;
        if (qo_v && qo_s) t_qs = $time;
        if (qo_v && qo_s) d_qs = qo_d;
        if (qo_v && qo_e) t_qe = $time;
        if (cyc == 8000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // latency in cycles must lie within the bounds shifted by the depth steps
    task automatic lat(input string nm, input int p, input time ti, input time to, input int dep);
        int l, lo, hi, sp, st;
        sp = int'(spd);
        st = dep * smb_pkg::STEP_NS[sp] / smb_pkg::CLK_NS;
        l  = int'((to - ti) / smb_pkg::CLK_NS);
        lo = (smb_pkg::LAT_MIN_NS[p][sp] + 3) / smb_pkg::CLK_NS + st;
        hi = smb_pkg::LAT_MAX_NS[p][sp] / smb_pkg::CLK_NS + st;
        `CHK(nm, 1'b1, (to > ti && l >= lo && l <= hi))
    endtask : lat
    // one copper word for a single cycle; no back-pressure on this side
    task automatic cu(input logic s, input logic e, input logic [3:0] lk, input logic [7:0] d, output time at);
        @(negedge clk);
        {cv, cs, ce, lck, cd} = {1'b1, s, e, lk, d};
        @(posedge clk);
        at = $time;
        @(negedge clk);
        {cv, cs, ce, cd} = {3'b000, 8'ha5};
    endtask : cu
    // quad to single at gig, start then terminate two cycles apart
    task automatic s_q2s();
        {t_ss, t_se} = 0;
        mac_q.send(8'h11, 1'b1, 1'b0, t0);
        mac_q.idle();
        mac_q.send(8'h00, 1'b0, 1'b1, t1);
        mac_q.idle();
        repeat (70) @(posedge clk);
        lat("q2s start", 0, t0, t_ss, 0);
        lat("q2s term", 0, t1, t_se, 0);
    endtask : s_q2s
    // quad to single at 100 with the deepest serial buffer, then at 10M with the least
    task automatic s_depth();
        @(negedge clk);
        {spd, sdep, t_ss} = {smb_pkg::SPD_100, 2'h3, 64'd0};
        mac_q.send(8'h22, 1'b1, 1'b0, t0);
        mac_q.idle();
        repeat (220) @(posedge clk);
        lat("q2s depth3", 0, t0, t_ss, 3);
        @(negedge clk);
        {spd, sdep, t_ss} = {smb_pkg::SPD_10, 2'h0, 64'd0};
        mac_q.send(8'h23, 1'b1, 1'b0, t0);
        mac_q.idle();
        repeat (1400) @(posedge clk);
        lat("q2s 10M", 0, t0, t_ss, 0);
    endtask : s_depth
    // single to quad at gig, once the slow egress slot has run out
    task automatic s_s2q();
        @(negedge clk);
        {spd, t_qs, t_qe} = {smb_pkg::SPD_1000, 128'd0};
        repeat (200) @(posedge clk);
        mac_s.send(8'h33, 1'b1, 1'b0, t0);
        mac_s.idle();
        mac_s.send(8'h00, 1'b0, 1'b1, t1);
        mac_s.idle();
        repeat (70) @(posedge clk);
        lat("s2q start", 1, t0, t_qs, 0);
        lat("s2q term", 1, t1, t_qe, 0);
        `CHK("s2q data", 8'h33, d_qs)
    endtask : s_s2q
    // loop mode: quad refused, single looped back to single
    task automatic s_loop();
        @(negedge clk);
        {ams, csel, t_ss} = {2'b10, 64'd0};
        repeat (3) @(posedge clk);
        `CHK("quad ready", 1'b0, qr)
        mac_s.send(8'h44, 1'b1, 1'b0, t0);
        mac_s.idle();
        repeat (100) @(posedge clk);
        lat("loop start", 2, t0, t_ss, 0);
    endtask : s_loop
    // copper into single: partial pair lock ignored, then full start and end codes
    task automatic s_cu();
        @(negedge clk);
        {csel, cdep, t_ss, t_se} = {1'b1, 2'h1, 128'd0};
        repeat (3) @(posedge clk);
        `CHK("single ready", 1'b0, sr)
        cu(1'b1, 1'b0, 4'h7, 8'h5a, t0);
        repeat (130) @(posedge clk);
        `CHK("skewed start", 64'd0, t_ss)
        cu(1'b1, 1'b0, 4'hf, 8'h5a, t0);
        cu(1'b0, 1'b1, 4'hf, 8'h5a, t1);
        repeat (130) @(posedge clk);
        lat("cu start", 3, t0, t_ss, 1);
        lat("cu term", 3, t1, t_se, 1);
    endtask : s_cu
    // copper 10M: delimiter, one byte, dribble nibble, end
    task automatic s_cu10();
        @(negedge clk);
        {spd, cdep, t_ss, t_se} = {smb_pkg::SPD_10, 2'h0, 128'd0};
        cu(1'b1, 1'b0, 4'hf, 8'h05, t0);
        cu(1'b0, 1'b0, 4'hf, 8'h0d, t0);
        cu(1'b0, 1'b0, 4'hf, 8'h04, t0);
        cu(1'b0, 1'b0, 4'hf, 8'h03, t0);
        cu(1'b0, 1'b0, 4'hf, 8'h09, t1);
        cu(1'b0, 1'b1, 4'hf, 8'h00, t1);
        repeat (2700) @(posedge clk);
        lat("cu10 sop", 3, t0, t_ss, 0);
        lat("cu10 eop", 3, t1, t_se, 0);
        `CHK("cu10 byte", 8'h34, d_ss)
    endtask : s_cu10
    // report counts and end the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // reset for four cycles, then each scenario in turn
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        s_q2s();
        s_depth();
        s_s2q();
        s_loop();
        s_cu();
        s_cu10();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
